// ===== verilog/gcr_pkg.sv
// constants and types for the gauge configuration register bank
// Operation
// - capacity lsb 0.5mAh, resistance 1/4096 ohm, time 5.625s; all unsigned from zero
// - voltage values unsigned, lsb 1.25mV/16, range zero to 5.11992V
// - percentage unsigned, lsb 1/256 percent; upper byte gives whole percent
// - current and temperature signed two's complement; temperature upper byte whole degrees
// - nominal capacity register resets to 0x0bb8
// - empty threshold register packs target high, recovery low; resets 0xa561
// - empty target 10mV steps, default 3.3V; zero percent declared there
// - recovery 40mV steps, default 3.88V; empty detect re-armed above it
// - host sets reload bit 15; device clears it when reload completes
// - registers reached by host over standard i2c for reads and writes
// - device holds a unique readable serial number; the bank holds the fixed SERIAL_DEFAULT, the same in every instance
package gcr_pkg;
  localparam logic [6:0] I2C_ADDR = 7'h36;
  localparam logic [7:0] NOMINAL_CAPACITY_OFS = 8'h18;
  localparam logic [7:0] EMPTY_THRESHOLD_OFS = 8'h3a;
  localparam logic [7:0] MODEL_SETTING_OFS = 8'hdb;
  localparam logic [7:0] SERIAL_BASE_OFS = 8'hd4;
  localparam logic [7:0] CELL_VOLTAGE_OFS = 8'h09;
  localparam logic [7:0] STATUS_OFS = 8'hd0;
  localparam logic [15:0] NOMINAL_CAPACITY_RST = 16'h0bb8;
  localparam logic [15:0] EMPTY_THRESHOLD_RST = 16'ha561;
  localparam logic [15:0] MODEL_SETTING_RST = 16'h0004;
  localparam logic [15:0] MODEL_WR_MASK = 16'ha4f0;
  localparam logic [15:0] MODEL_FIXED_ONE = 16'h0004;
  localparam int RELOAD_BIT = 15;
  localparam int THERM_BIT = 13;
  localparam int HIGH_CHG_BIT = 10;
  localparam int TARGET_LSB = 7;
  localparam int RECOVERY_W = 7;
  // empty target field 10mV, recovery 40mV, cell voltage 1.25mV/16
  localparam int TARGET_UV_PER_STEP = 10000;
  localparam int RECOVERY_UV_PER_STEP = 40000;
  localparam int VOLT_LSB_NV = 78125;
  localparam int RELOAD_TIME_US = 1000;
  localparam int CLK_NS = 100;
  localparam int RELOAD_CYCLES = (RELOAD_TIME_US * 1000) / CLK_NS;
  // serial value is arbitrary
  localparam logic [63:0] SERIAL_DEFAULT = 64'h0123_4567_89ab_cdef;
  typedef struct packed {
    logic empty_flag;
    logic reload_busy;
  } gcr_status_s;
  typedef enum logic [2:0] {
    GCR_IDLE, GCR_ADDR, GCR_PTR, GCR_WLO, GCR_WHI, GCR_RD, GCR_ACK
  } gcr_state_e;
endpackage

// ===== verilog/gcr_serial_rom.sv
// serial number store with registered read data
`timescale 1ns/1ns
module gcr_serial_rom #(
  parameter logic [63:0] SERIAL = gcr_pkg::SERIAL_DEFAULT
) (
  // clock
  input wire logic clk,
  // read port
  input wire logic [1:0] word_sel,
  output logic [15:0] word_data
);
  import gcr_pkg::*;
  wire logic [15:0] word_mux;
  assign word_mux = SERIAL[{word_sel, 4'h0} +: 16];
  always_ff @(posedge clk) begin
    word_data <= word_mux;
  end
endmodule

// ===== verilog/gcr_register_bank.sv
// configuration register bank reached over i2c
`timescale 1ns/1ns
module gcr_register_bank #(
  parameter int RELOAD_CYC = gcr_pkg::RELOAD_CYCLES
) (
  // clock and reset
  input wire logic clk,
  input wire logic reset,
  // i2c pins, sampled synchronously
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  // cell voltage from the measurement path
  input wire logic [15:0] cell_voltage,
  // configuration and state to the algorithm
  output logic [15:0] nominal_cell_capacity,
  output logic [15:0] empty_threshold_setting,
  output logic [15:0] algorithm_model_setting,
  output gcr_pkg::gcr_status_s status
);
  import gcr_pkg::*;
  gcr_state_e state;
  logic scl_q, sda_q;
  logic [7:0] shreg;
  logic [3:0] bitcnt;
  logic [7:0] ptr;
  logic [7:0] wlo;
  logic ack_ph;
  gcr_state_e next_rx;
  logic [15:0] rdata;
  logic rd_hi;
  logic [$clog2(RELOAD_CYC+1)-1:0] reload_cnt;
  logic [15:0] serial_word;
  wire logic scl_rise, scl_fall, start_c, stop_c;
  wire logic byte_done, wr_strobe;
  wire logic [15:0] wdata, model_next, rd_mux;
  wire logic [31:0] cell_uv, target_uv, recovery_uv;
  wire logic reload_done;
  wire logic rx_state, rx_bit, addr_hit;
  wire logic [7:0] rd_byte;
  wire logic [63:0] cell_nv;
  assign rx_state = (state == GCR_ADDR) || (state == GCR_PTR)
    || (state == GCR_WLO) || (state == GCR_WHI);
  assign rx_bit = scl_rise & rx_state & ~ack_ph & (bitcnt < 4'd8);
  assign addr_hit = (shreg[7:1] == I2C_ADDR);
  assign next_rx = (state == GCR_ADDR) ? (shreg[0] ? GCR_RD : GCR_PTR) :
    (state == GCR_WLO) ? GCR_WHI : GCR_WLO;
  // low byte of a word is sent first; the high byte can only follow it
  assign rd_byte = rd_hi ? rdata[15:8] : rdata[7:0];
  assign scl_rise = scl_in & ~scl_q;
  assign scl_fall = ~scl_in & scl_q;
  assign start_c = scl_in & scl_q & sda_q & ~sda_in;
  assign stop_c = scl_in & scl_q & ~sda_q & sda_in;
  assign byte_done = scl_fall & (bitcnt == 4'd8);
  assign wdata = {shreg, wlo};
  assign wr_strobe = byte_done & (state == GCR_WHI);
  // fixed bits forced, writable fields kept
  assign model_next = (wdata & MODEL_WR_MASK) | MODEL_FIXED_ONE;
  // voltages in microvolts for empty detection
  assign cell_nv = 64'(cell_voltage) * 64'(VOLT_LSB_NV);
  assign cell_uv = 32'(cell_nv / 64'd1000);
  assign target_uv = 32'(empty_threshold_setting[15:TARGET_LSB])
    * 32'(TARGET_UV_PER_STEP);
  assign recovery_uv = 32'(empty_threshold_setting[RECOVERY_W-1:0])
    * 32'(RECOVERY_UV_PER_STEP);
  assign reload_done = status.reload_busy
    && (32'(reload_cnt) == 32'(RELOAD_CYC - 1));
  assign rd_mux = (ptr == NOMINAL_CAPACITY_OFS) ? nominal_cell_capacity :
    (ptr == EMPTY_THRESHOLD_OFS) ? empty_threshold_setting :
    (ptr == MODEL_SETTING_OFS) ? algorithm_model_setting :
    (ptr == CELL_VOLTAGE_OFS) ? cell_voltage :
    (ptr == STATUS_OFS) ? {14'h0, status} :
    (ptr[7:2] == SERIAL_BASE_OFS[7:2]) ? serial_word : 16'h0000;

  gcr_serial_rom u_rom (
    .clk(clk),
    .word_sel(ptr[1:0]),
    .word_data(serial_word)
  );

  always_ff @(posedge clk) begin
    scl_q <= scl_in;
    sda_q <= sda_in;
  end

  // i2c target: word registers little endian, pointer then data
  always_ff @(posedge clk) begin
    if (reset || stop_c) begin
      state <= GCR_IDLE;
      bitcnt <= 4'd0;
      ack_ph <= 1'b0;
      sda_oe <= 1'b0;
      sda_out <= 1'b0;
    end else if (start_c) begin
      state <= GCR_ADDR;
      bitcnt <= 4'd0;
      ack_ph <= 1'b0;
      sda_oe <= 1'b0;
    end else if (rx_bit) begin
      shreg <= {shreg[6:0], sda_in};
      bitcnt <= bitcnt + 4'd1;
    end else if (byte_done && state == GCR_RD) begin
      // read byte out, release for the host acknowledge
      bitcnt <= 4'd0;
      sda_oe <= 1'b0;
      state <= GCR_ACK;
    end else if (byte_done) begin
      bitcnt <= 4'd0;
      if (state == GCR_ADDR && !addr_hit) begin
        state <= GCR_IDLE;
      end else begin
        ack_ph <= 1'b1;
        sda_oe <= 1'b1;
        state <= next_rx;
      end
      if (state == GCR_ADDR) begin
        rd_hi <= 1'b0;
        rdata <= rd_mux;
      end
      if (state == GCR_PTR) begin
        ptr <= shreg;
      end
      if (state == GCR_WLO) begin
        wlo <= shreg;
      end
      if (state == GCR_WHI) begin
        ptr <= ptr + 8'd1;
      end
    end else if (scl_fall && ack_ph) begin
      // ack clock over, load first read bit or release
      ack_ph <= 1'b0;
      if (state == GCR_RD) begin
        sda_oe <= ~rd_byte[7];
        shreg <= rd_byte;
        bitcnt <= 4'd1;
      end else begin
        sda_oe <= 1'b0;
      end
    end else if (scl_fall && state == GCR_RD && bitcnt != 4'd0) begin
      sda_oe <= ~shreg[3'd7 - bitcnt[2:0]];
      bitcnt <= bitcnt + 4'd1;
    end else if (scl_rise && state == GCR_ACK) begin
      if (sda_in) begin
        state <= GCR_IDLE;
      end else begin
        state <= GCR_RD;
        ack_ph <= 1'b1;
        if (rd_hi) begin
          ptr <= ptr + 8'd1;
        end
        rd_hi <= ~rd_hi;
      end
    end
  end

  // register storage
  always_ff @(posedge clk) begin
    if (reset) begin
      nominal_cell_capacity <= NOMINAL_CAPACITY_RST;
      empty_threshold_setting <= EMPTY_THRESHOLD_RST;
      algorithm_model_setting <= MODEL_SETTING_RST;
    end else begin
      if (wr_strobe && ptr == NOMINAL_CAPACITY_OFS) begin
        nominal_cell_capacity <= wdata;
      end
      if (wr_strobe && ptr == EMPTY_THRESHOLD_OFS) begin
        empty_threshold_setting <= wdata;
      end
      // host write to set wins over completion clear
      if (wr_strobe && ptr == MODEL_SETTING_OFS) begin
        algorithm_model_setting <= model_next;
      end else if (reload_done) begin
        algorithm_model_setting[RELOAD_BIT] <= 1'b0;
      end
    end
  end

  // reload sequencer and empty detection
  always_ff @(posedge clk) begin
    if (reset) begin
      status <= '0;
      reload_cnt <= '0;
    end else begin
      status.reload_busy <= algorithm_model_setting[RELOAD_BIT]
        & ~reload_done;
      reload_cnt <= status.reload_busy && !reload_done ?
        reload_cnt + 1'b1 : '0;
      if (cell_uv > recovery_uv) begin
        status.empty_flag <= 1'b0;
      end else if (cell_uv <= target_uv) begin
        status.empty_flag <= 1'b1;
      end
    end
  end

  sequence s_reload_end;
    reload_done && !(wr_strobe && ptr == MODEL_SETTING_OFS);
  endsequence
  sequence s_bit_low;
    !algorithm_model_setting[RELOAD_BIT];
  endsequence
  property p_reload_clears;
    @(posedge clk) disable iff (reset) s_reload_end |=> s_bit_low;
  endproperty
  a_reload_clear: assert property (p_reload_clears)
    else $error("reload bit not cleared");
  a_reload_bound: assert property (@(posedge clk) disable iff (reset)
    status.reload_busy |-> 32'(reload_cnt) < 32'(RELOAD_CYC))
    else $error("reload count past its limit");
  a_capacity_reset: assert property (@(posedge clk)
    $past(reset) |-> nominal_cell_capacity == 16'h0bb8)
    else $error("capacity reset value wrong");
  a_empty_reset: assert property (@(posedge clk)
    $past(reset) |-> empty_threshold_setting == 16'ha561)
    else $error("empty threshold reset value wrong");
  a_model_fixed: assert property (@(posedge clk) disable iff (reset)
    algorithm_model_setting[2] && !algorithm_model_setting[0])
    else $error("model fixed bits wrong");
  a_empty_rearm: assert property (@(posedge clk) disable iff (reset)
    (cell_uv > recovery_uv) |=> !status.empty_flag)
    else $error("empty not cleared above recovery");
endmodule

// ===== dv/gcr_host_model.sv
// i2c host model driving scl and the host side of sda
`timescale 1ns/1ns
module gcr_host_model (
  // clock
  input wire logic clk,
  // bus, sda level resolved in the bench with a pull-up
  input wire logic sda,
  output logic scl,
  output logic sda_low
);
  initial begin
    scl = 1'b1;
    sda_low = 1'b0;
  end
  task automatic q();
    repeat (3) @(negedge clk);
  endtask
  // start or repeated start
  task automatic start();
    sda_low = 1'b0;
    q();
    scl = 1'b1;
    q();
    sda_low = 1'b1;
    q();
    scl = 1'b0;
    q();
  endtask
  task automatic stop();
    sda_low = 1'b1;
    q();
    scl = 1'b1;
    q();
    sda_low = 1'b0;
    q();
  endtask
  // one bit, data only changes while scl is low
  task automatic bit_io(input logic b, output logic r);
    sda_low = ~b;
    q();
    scl = 1'b1;
    q();
    r = sda;
    q();
    scl = 1'b0;
    q();
  endtask
  // eight bits msb first, then the acknowledge bit
  task automatic xfer(input logic [7:0] w, input logic last,
      output logic [7:0] r, output logic nack);
    for (int i = 7; i >= 0; i--) begin
      bit_io(w[i], r[i]);
    end
    bit_io(last, nack);
  endtask
endmodule

// ===== dv/tb.sv
// self-checking bench for the gauge configuration register bank
`timescale 1ns/1ns
module tb;
  import gcr_pkg::*;
  logic clk, reset, scl, sda_low, sda_out, sda_oe, nk, fl;
  logic [15:0] cell_voltage, cap, thr, mdl, rv, v;
  gcr_status_s status;
  wire sda = ~(sda_low | sda_oe);
  int fail_count = 0;
  int samples_checked = 0;
  int regs[int];
  int seen;
  logic [7:0] offs[4] = '{8'h18, 8'h3a, 8'hdb, 8'h40};
  logic [15:0] cvs[4] = '{16'h9000, 16'hb000, 16'hd000, 16'hb000};
  gcr_register_bank #(.RELOAD_CYC(8)) uut (.clk(clk), .reset(reset),
    .scl_in(scl), .sda_in(sda), .sda_out(sda_out), .sda_oe(sda_oe),
    .cell_voltage(cell_voltage), .nominal_cell_capacity(cap),
    .empty_threshold_setting(thr), .algorithm_model_setting(mdl),
    .status(status));
  gcr_host_model h (.clk(clk), .sda(sda), .scl(scl), .sda_low(sda_low));
  task automatic check(input string n, input logic [15:0] e, g);
    samples_checked++;
    if (g !== e) begin
      fail_count++;
      $display("wrong value %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic wr(input logic [6:0] a, input logic [7:0] p,
      input logic [15:0] d);
    logic [7:0] r;
    logic n;
    h.start();
    h.xfer({a, 1'b0}, 1'b1, r, nk);
    h.xfer(p, 1'b1, r, n);
    h.xfer(d[7:0], 1'b1, r, n);
    h.xfer(d[15:8], 1'b1, r, n);
    h.stop();
    if (a == 7'h36 && p == 8'hdb) regs[p] = (d & 16'h24f0) | 16'h0004;
    else if (a == 7'h36 && regs.exists(p)) regs[p] = d;
  endtask
  task automatic rchk(input logic [7:0] p);
    logic [7:0] r;
    logic n;
    h.start();
    h.xfer({7'h36, 1'b0}, 1'b1, r, n);
    h.xfer(p, 1'b1, r, n);
    h.start();
    h.xfer({7'h36, 1'b1}, 1'b1, r, n);
    h.xfer(8'hff, 1'b0, rv[7:0], n);
    h.xfer(8'hff, 1'b1, rv[15:8], n);
    h.stop();
    check("readback", regs.exists(p) ? 16'(regs[p]) : 16'h0000, rv);
  endtask
  task automatic pchk();
    check("capacity", 16'(regs[8'h18]), cap);
    check("thresholds", 16'(regs[8'h3a]), thr);
    check("model", 16'(regs[8'hdb]), mdl);
    check("sda_out", 16'h0000, 16'(sda_out));
  endtask
  task automatic test_done();
    if (fail_count == 0 && samples_checked > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  initial begin
    #6000000;
    fail_count++;
    test_done();
  end
  initial begin
    reset = 1'b1;
    cell_voltage = 16'hd000;
    fl = 1'b0;
    void'($urandom(64));
    regs[8'h18] = 16'h0bb8;
    regs[8'h3a] = 16'ha561;
    regs[8'hdb] = 16'h0004;
    repeat (3) @(negedge clk);
    reset = 1'b0;
    pchk();
    foreach (offs[i]) rchk(offs[i]);
    for (int i = 0; i < 3; i++) begin
      wr(7'h36, 8'h18, 16'($urandom));
      wr(7'h36, 8'h3a, 16'($urandom));
      wr(7'h36, 8'h40, 16'($urandom));
      foreach (offs[j]) rchk(offs[j]);
    end
    wr(7'h35, 8'h18, 16'h1234);
    check("foreign address ack", 16'h0001, 16'(nk));
    rchk(8'h18);
    foreach (cvs[i]) begin
      v = 16'($urandom) & 16'h7fff;
      v[7:4] = (i == 0) ? 4'h0 : (i == 1) ? 4'h2 : 4'h6;
      wr(7'h36, 8'hdb, v);
      rchk(8'hdb);
    end
    seen = 0;
    fork
      wr(7'h36, 8'hdb, 16'h8004);
      repeat (900) @(posedge clk) if (mdl[15] === 1'b1) seen = 1;
    join
    repeat (30) @(negedge clk);
    check("reload set", 16'h0001, 16'(seen));
    pchk();
    wr(7'h36, 8'h3a, 16'ha561);
    foreach (cvs[i]) begin
      cell_voltage = cvs[i];
      if (longint'(cvs[i]) * 78125 <= longint'(regs[8'h3a] >> 7) * 10000000)
        fl = 1'b1;
      else if (longint'(cvs[i]) * 78125 >
          longint'(regs[8'h3a] & 127) * 40000000)
        fl = 1'b0;
      repeat (6) @(negedge clk);
      check("empty flag", 16'(fl), 16'(status.empty_flag));
    end
    regs[8'hd4] = int'(SERIAL_DEFAULT[15:0]);
    rchk(8'hd4);
    regs[8'hd5] = int'(SERIAL_DEFAULT[31:16]);
    rchk(8'hd5);
    test_done();
  end
endmodule
